// *** pilt_consts.vh ***
// Constants for the privacy indicator and LED temperature monitor
// Contract
// - Indicator current code sets indicator LED current
// - Reverse indicator only when power stage off
// - Reverse mode pulls converter output to ground
// - White LED dimming uses 30 kHz PWM
// - PWM timer runs from internal oscillator
// - Dimming duty comes from indicator code
// - Dimming only in mode 01 with voltage enable
// - Dimming applies to selected LED channels only
// - Dimming disables video light safety timeout
// - Two stage temperature: warning informs, hot suspends
// - Flags from comparators at 1.05 and 0.345 V
// - Monitoring active in video light and flash
// - Voltage mode monitors only with sense enable
// - Timers limit flash and video light on-time
// - Warning flag follows low sense voltage
// - Hot flag latches while regulating current
// - Hot event clears mode, sets die temperature field
`ifndef PILT_CONSTS_VH
`define PILT_CONSTS_VH
`define PILT_CLK_MHZ        200
`define PILT_PWM_FREQ_KHZ   30
`define PILT_PWM_PERIOD     ((`PILT_CLK_MHZ * 1000) / `PILT_PWM_FREQ_KHZ)
`define PILT_PWM_STEP       (`PILT_PWM_PERIOD / 15)
`define PILT_MODE_OFF       2'b00
`define PILT_MODE_VIDEO     2'b01
`define PILT_MODE_FLASH     2'b10
`define PILT_MODE_VOLT      2'b11
`define PILT_DIE_TRIPPED    2'b11
`define PILT_ADDR_CTRL      4'h0
`define PILT_ADDR_STATUS    4'h1
`define PILT_ADDR_IRQ_ST    4'h2
`define PILT_ADDR_IRQ_MASK  4'h3
`define PILT_ADDR_TIMERS    4'h4
`define PILT_CTRL_MODE_LSB  0
`define PILT_CTRL_VM_BIT    2
`define PILT_CTRL_TS_BIT    3
`define PILT_CTRL_REV_BIT   4
`define PILT_CTRL_LED_LSB   5
`define PILT_CTRL_IND_LSB   8
`define PILT_CTRL_RESET     32'h0000_0000
`define PILT_FLASH_LIMIT_RESET 16'h0100
`define PILT_VIDEO_LIMIT_RESET 16'hffff
`define PILT_TICK_DIV       16'd50000
`endif

// *** pilt_pwm.v ***
// Fixed-period PWM generator for white LED dimming
`timescale 1ns/1ps
`include "pilt_consts.vh"
module pilt_pwm
(
  input  wire       clk_in,
  input  wire       rst_in,
  input  wire       ce_in,
  input  wire       enable_in,
  input  wire [3:0] duty_code_in,
  output reg        pwm_out
);
  reg  [12:0] count_reg;
  wire [12:0] on_time;
  wire [31:0] on_time_full;

  // Internal clock only, so frequency tracks oscillator
  assign on_time_full = duty_code_in * `PILT_PWM_STEP;
  // Largest code times step stays below the period, so the cut is lossless
  assign on_time = on_time_full[12:0];

  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      count_reg <= 13'h0000;
      pwm_out   <= 1'b0;
    end
    else if (ce_in)
    begin
      if (!enable_in || count_reg == `PILT_PWM_PERIOD - 1)
        count_reg <= 13'h0000;
      else
        count_reg <= count_reg + 13'h0001;
      pwm_out <= enable_in && (count_reg < on_time);
    end
  end
endmodule // pilt_pwm

// *** pilt_top.v ***
// Privacy indicator and LED temperature monitor top level
`timescale 1ns/1ps
`include "pilt_consts.vh"
module pilt_top
(
  input  wire        clk_in,
  input  wire        rst_in,
  input  wire        ce_in,
  input  wire [3:0]  addr_in,
  input  wire [31:0] wdata_in,
  input  wire        wr_in,
  input  wire        rd_in,
  output reg  [31:0] rdata_out,
  input  wire        ts_warn_cmp_in,
  input  wire        ts_hot_cmp_in,
  input  wire        die_hot_in,
  output reg  [3:0]  indicator_current_code_out,
  output reg         indicator_reverse_out,
  output reg         converter_output_node_pulldown_out,
  output reg  [2:0]  led_drive_out,
  output reg  [1:0]  mode_out,
  output reg         ts_bias_enable_out,
  output reg         flash_timeout_out,
  output reg         video_timeout_out,
  output wire        irq_out
);
  reg  [1:0]  mode_reg;
  reg         voltage_mode_enable_reg;
  reg         thermistor_sense_enable_reg;
  reg         reverse_req_reg;
  reg  [2:0]  led_channel_select_reg;
  reg  [3:0]  indicator_current_code_reg;
  reg  [1:0]  die_temperature_field_reg;
  reg         led_temp_warning_flag_reg;
  reg         led_overtemp_flag_reg;
  reg  [2:0]  irq_status_reg;
  reg  [2:0]  irq_mask_reg;
  reg  [15:0] flash_limit_reg;
  reg  [15:0] video_limit_reg;
  reg  [15:0] tick_cnt_reg;
  reg  [15:0] on_cnt_reg;
  reg  [2:0]  warn_sync_reg;
  reg  [2:0]  hot_sync_reg;
  reg         warn_state_reg;
  reg         hot_state_reg;
  reg  [31:0] rdata_next;
  wire        power_off;
  wire        dim_active;
  wire        monitor_active;
  wire        regulating;
  wire        pwm;
  wire        tick;
  wire        hot_event;
  wire        warn_rise;
  wire        timeout_event;
  wire        wr_ctrl;
  wire        wr_irq_st;

  assign wr_ctrl   = wr_in && addr_in == `PILT_ADDR_CTRL;
  assign wr_irq_st = wr_in && addr_in == `PILT_ADDR_IRQ_ST;
  assign power_off = mode_reg == `PILT_MODE_OFF && !voltage_mode_enable_reg;
  assign dim_active = mode_reg == `PILT_MODE_VIDEO && voltage_mode_enable_reg;
  assign regulating = mode_reg == `PILT_MODE_VIDEO || mode_reg == `PILT_MODE_FLASH;
  assign monitor_active = regulating
                       || (mode_reg == `PILT_MODE_VOLT && thermistor_sense_enable_reg);
  assign tick = tick_cnt_reg == `PILT_TICK_DIV - 16'd1;

  // Change counts once the second and third stages agree
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      warn_sync_reg  <= 3'h0;
      hot_sync_reg   <= 3'h0;
      warn_state_reg <= 1'b0;
      hot_state_reg  <= 1'b0;
    end
    else if (ce_in)
    begin
      warn_sync_reg <= {warn_sync_reg[1:0], ts_warn_cmp_in};
      hot_sync_reg  <= {hot_sync_reg[1:0], ts_hot_cmp_in};
      if (warn_sync_reg[1] == warn_sync_reg[2])
        warn_state_reg <= warn_sync_reg[2];
      if (hot_sync_reg[1] == hot_sync_reg[2])
        hot_state_reg <= hot_sync_reg[2];
    end
  end

  // Comparators high when sense is below 1.05 V / 0.345 V
  assign hot_event = monitor_active && regulating && hot_state_reg;
  assign warn_rise = monitor_active && warn_state_reg && !led_temp_warning_flag_reg;
  assign timeout_event = (flash_timeout_out == 1'b0 && mode_reg == `PILT_MODE_FLASH
                          && on_cnt_reg >= flash_limit_reg)
                       || (mode_reg == `PILT_MODE_VIDEO && !dim_active && on_cnt_reg >= video_limit_reg);

  pilt_pwm u_pwm
  (
    .clk_in       (clk_in),
    .rst_in       (rst_in),
    .ce_in        (ce_in),
    .enable_in    (dim_active),
    .duty_code_in (indicator_current_code_reg),
    .pwm_out      (pwm)
  );

  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      mode_reg                    <= `PILT_MODE_OFF;
      voltage_mode_enable_reg     <= 1'b0;
      thermistor_sense_enable_reg <= 1'b0;
      reverse_req_reg             <= 1'b0;
      led_channel_select_reg      <= 3'h0;
      indicator_current_code_reg  <= 4'h0;
      die_temperature_field_reg   <= 2'h0;
      led_temp_warning_flag_reg   <= 1'b0;
      led_overtemp_flag_reg       <= 1'b0;
      irq_status_reg              <= 3'h0;
      irq_mask_reg                <= 3'h0;
      flash_limit_reg             <= `PILT_FLASH_LIMIT_RESET;
      video_limit_reg             <= `PILT_VIDEO_LIMIT_RESET;
      tick_cnt_reg                <= 16'h0000;
      on_cnt_reg                  <= 16'h0000;
      flash_timeout_out           <= 1'b0;
      video_timeout_out           <= 1'b0;
      rdata_out                   <= 32'h0000_0000;
    end
    else if (ce_in)
    begin
      rdata_out <= rd_in ? rdata_next : 32'h0000_0000;
      if (wr_ctrl)
      begin
        mode_reg                    <= wdata_in[`PILT_CTRL_MODE_LSB +: 2];
        voltage_mode_enable_reg     <= wdata_in[`PILT_CTRL_VM_BIT];
        thermistor_sense_enable_reg <= wdata_in[`PILT_CTRL_TS_BIT];
        reverse_req_reg             <= wdata_in[`PILT_CTRL_REV_BIT];
        led_channel_select_reg      <= wdata_in[`PILT_CTRL_LED_LSB +: 3];
        indicator_current_code_reg  <= wdata_in[`PILT_CTRL_IND_LSB +: 4];
      end
      if (wr_in && addr_in == `PILT_ADDR_IRQ_MASK)
        irq_mask_reg <= wdata_in[2:0];
      if (wr_in && addr_in == `PILT_ADDR_TIMERS)
      begin
        flash_limit_reg <= wdata_in[15:0];
        video_limit_reg <= wdata_in[31:16];
      end
      // Suspend wins over a concurrent mode write
      if (hot_event)
      begin
        mode_reg                  <= `PILT_MODE_OFF;
        die_temperature_field_reg <= `PILT_DIE_TRIPPED;
        led_overtemp_flag_reg     <= 1'b1;
      end
      else if (die_hot_in)
        die_temperature_field_reg <= `PILT_DIE_TRIPPED;
      else if (rd_in && addr_in == `PILT_ADDR_STATUS)
      begin
        die_temperature_field_reg <= 2'h0;
        led_overtemp_flag_reg     <= 1'b0;
      end
      // Warning only informs, never touches the mode
      led_temp_warning_flag_reg <= monitor_active && warn_state_reg;
      // Set wins over write-one-to-clear
      irq_status_reg <= (irq_status_reg & ~(wr_irq_st ? wdata_in[2:0] : 3'h0))
                      | {timeout_event, hot_event, warn_rise};
      // Coarse tick keeps on-time counters narrow
      tick_cnt_reg <= tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
      if (!regulating || wr_ctrl)
        on_cnt_reg <= 16'h0000;
      else if (tick && on_cnt_reg != 16'hffff)
        on_cnt_reg <= on_cnt_reg + 16'h0001;
      if (wr_ctrl)
      begin
        flash_timeout_out <= 1'b0;
        video_timeout_out <= 1'b0;
      end
      else if (timeout_event)
      begin
        mode_reg          <= `PILT_MODE_OFF;
        flash_timeout_out <= mode_reg == `PILT_MODE_FLASH;
        video_timeout_out <= mode_reg == `PILT_MODE_VIDEO;
      end
    end
  end

  always @*
  begin
    case (addr_in)
      `PILT_ADDR_CTRL:
        rdata_next = {20'h00000, indicator_current_code_reg, led_channel_select_reg, reverse_req_reg,
                      thermistor_sense_enable_reg, voltage_mode_enable_reg, mode_reg};
      `PILT_ADDR_STATUS:
        rdata_next = {26'h0000000, dim_active, monitor_active, die_temperature_field_reg,
                      led_overtemp_flag_reg, led_temp_warning_flag_reg};
      `PILT_ADDR_IRQ_ST:   rdata_next = {29'h00000000, irq_status_reg};
      `PILT_ADDR_IRQ_MASK: rdata_next = {29'h00000000, irq_mask_reg};
      `PILT_ADDR_TIMERS:   rdata_next = {video_limit_reg, flash_limit_reg};
      default:             rdata_next = 32'h0000_0000;
    endcase
  end

  assign irq_out = |(irq_status_reg & irq_mask_reg);

  // Outputs registered so pins never glitch on decode
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      indicator_current_code_out         <= 4'h0;
      indicator_reverse_out              <= 1'b0;
      converter_output_node_pulldown_out <= 1'b0;
      led_drive_out                      <= 3'h0;
      mode_out                           <= `PILT_MODE_OFF;
      ts_bias_enable_out                 <= 1'b0;
    end
    else if (ce_in)
    begin
      indicator_current_code_out         <= indicator_current_code_reg;
      indicator_reverse_out              <= reverse_req_reg && power_off;
      converter_output_node_pulldown_out <= reverse_req_reg && power_off;
      led_drive_out                      <= regulating ?
                                            (dim_active ? (led_channel_select_reg & {3{pwm}})
                                                        : led_channel_select_reg) : 3'h0;
      mode_out                           <= mode_reg;
      ts_bias_enable_out                 <= monitor_active;
    end
  end
endmodule // pilt_top

// *** pilt_properties.sv ***
// Port checker for the indicator and temperature monitor
`timescale 1ns/1ps
module pilt_props
(
  input wire        clk_in,
  input wire        rst_in,
  input wire        ce_in,
  input wire [3:0]  addr_in,
  input wire [31:0] wdata_in,
  input wire        wr_in,
  input wire        ts_warn_cmp_in,
  input wire        ts_hot_cmp_in,
  input wire [3:0]  indicator_current_code_out,
  input wire        indicator_reverse_out,
  input wire        converter_output_node_pulldown_out,
  input wire [2:0]  led_drive_out,
  input wire [1:0]  mode_out,
  input wire        ts_bias_enable_out
);
  // Shadow of the control word, so outputs can be tied to what was written
  reg [11:0] ctrl_reg;
  always @(posedge clk_in)
  begin
    if (rst_in)
      ctrl_reg <= 12'h000;
    else if (ce_in && wr_in && addr_in == 4'h0)
      ctrl_reg <= wdata_in[11:0];
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  rev_gate_a: assert property (indicator_reverse_out |-> mode_out == 2'b00)
    else $error("reverse path on while powered");
  rev_pull_a: assert property (indicator_reverse_out |-> converter_output_node_pulldown_out)
    else $error("reverse path without pulldown");
  code_wr_a: assert property (wr_in && ce_in && addr_in == 4'h0 |-> ##[1:2] indicator_current_code_out == ctrl_reg[11:8])
    else $error("indicator code not applied");
  hot_stop_a: assert property ($rose(ts_hot_cmp_in) && (mode_out == 2'b01 || mode_out == 2'b10) |-> ##[1:10] mode_out == 2'b00)
    else $error("hot event did not suspend");
  warn_keep_a: assert property ($rose(ts_warn_cmp_in) && mode_out == 2'b01 ##0 !ts_hot_cmp_in [*8] |-> mode_out == 2'b01)
    else $error("warning changed the mode");
  bias_on_a: assert property ((mode_out == 2'b01 || mode_out == 2'b10) [*2] |-> ts_bias_enable_out)
    else $error("monitoring off in led mode");
  led_sel_a: assert property (!$past(wr_in) |-> (led_drive_out & ~ctrl_reg[7:5]) == 3'b000)
    else $error("unselected channel driven");
  volt_bias_a: assert property (mode_out == 2'b11 && !ctrl_reg[3] && !$past(wr_in) |-> !ts_bias_enable_out)
    else $error("sense active without enable");
  cover property (indicator_reverse_out);
  cover property ($rose(led_drive_out[0]));
  cover property ($fell(mode_out[0]));
endmodule // pilt_props

bind pilt_top pilt_props i_pilt_props (.clk_in, .rst_in, .ce_in, .addr_in, .wdata_in, .wr_in, .ts_warn_cmp_in,
  .ts_hot_cmp_in, .indicator_current_code_out, .indicator_reverse_out, .converter_output_node_pulldown_out,
  .led_drive_out, .mode_out, .ts_bias_enable_out);

// *** testbench.sv ***
// Self-checking bench for the indicator and temperature monitor
`timescale 1ns/1ps
module testbench;
  reg         clk_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0, warn_in = 1'b0, hot_in = 1'b0;
  reg  [3:0]  addr_in = 4'h0;
  reg  [31:0] wdata_in = 32'h0000_0000, d;
  wire [31:0] rdata_out;
  wire [3:0]  code_out;
  wire [2:0]  led_out;
  wire [1:0]  mode_out;
  wire        rev_out, pull_out, bias_out, ftmo_out, vtmo_out, irq_out;
  integer     fail_count = 0, compares = 0, i, n0, n1;
  // Die trip tied off: its field is shared with the hot path checked here
  pilt_top i_pilt_top (.clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .ts_warn_cmp_in(warn_in), .ts_hot_cmp_in(hot_in),
    .die_hot_in(1'b0), .indicator_current_code_out(code_out), .indicator_reverse_out(rev_out),
    .converter_output_node_pulldown_out(pull_out), .led_drive_out(led_out), .mode_out(mode_out),
    .ts_bias_enable_out(bias_out), .flash_timeout_out(ftmo_out), .video_timeout_out(vtmo_out), .irq_out(irq_out));
  initial
  begin
    forever #2.5 clk_in = ~clk_in;
  end
  task check(input [31:0] got, input [31:0] exp);
  begin
    compares = compares + 1;
    if (got !== exp)
    begin
      fail_count = fail_count + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task cyc(input integer n);
  begin
    repeat (n) @(posedge clk_in);
    #1;
  end
  endtask
  task wr(input [3:0] a, input [31:0] v);
  begin
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  end
  endtask
  task rd(input [3:0] a);
  begin
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  end
  endtask
  function [31:0] ctl(input [1:0] m, input vm, input ts, input rv, input [2:0] led, input [3:0] c);
    ctl = {20'h00000, c, led, rv, ts, vm, m};
  endfunction
  task t_reset;
  begin
    check({17'h00000, code_out, rev_out, pull_out, led_out, mode_out, bias_out, ftmo_out, vtmo_out, irq_out}, 32'h0);
    wr(4'hf, 32'hffff_ffff);
    rd(4'hf);
    check(d, 32'h0);
    rd(4'h1);
    check(d, 32'h0);
  end
  endtask
  task t_ind;
  begin
    for (i = 0; i < 16; i = i + 1)
    begin
      wr(4'h0, ctl(2'b00, 1'b0, 1'b0, 1'b1, 3'b000, i[3:0]));
      cyc(3);
      check({26'h0, code_out, rev_out, pull_out}, {26'h0, i[3:0], 2'b11});
    end
    wr(4'h0, ctl(2'b00, 1'b1, 1'b0, 1'b1, 3'b000, 4'h3));
    cyc(3);
    check({30'h0, rev_out, pull_out}, 32'h0);
    wr(4'h0, ctl(2'b01, 1'b0, 1'b0, 1'b1, 3'b000, 4'h3));
    cyc(3);
    check({30'h0, rev_out, pull_out}, 32'h0);
  end
  endtask
  task t_dim;
  begin
    wr(4'h4, 32'h0001_0100);
    for (i = 0; i < 2; i = i + 1)
    begin
      wr(4'h0, ctl(2'b01, 1'b1, 1'b0, 1'b0, 3'b101, i ? 4'hf : 4'h1));
      cyc(3);
      rd(4'h1);
      check({31'h0, d[5]}, 32'h1);
      n0 = 0;
      n1 = 0;
      repeat (6666)
      begin
        cyc(1);
        n0 = n0 + led_out[0];
        n1 = n1 + led_out[1];
      end
      check(n0, i ? 6660 : 444);
      check(n1, 0);
    end
    // Dimmed run outlasts a one-tick video limit
    cyc(40000);
    check({31'h0, vtmo_out}, 32'h0);
    wr(4'h4, 32'hffff_0100);
    wr(4'h0, ctl(2'b01, 1'b0, 1'b0, 1'b0, 3'b001, 4'h0));
    cyc(3);
    rd(4'h1);
    check({31'h0, d[5]}, 32'h0);
    check({31'h0, bias_out}, 32'h1);
  end
  endtask
  task t_temp;
  begin
    @(posedge clk_in);
    warn_in <= 1'b1;
    cyc(10);
    rd(4'h1);
    check({30'h0, d[1:0]}, 32'h1);
    check({30'h0, mode_out}, 32'h1);
    check({31'h0, irq_out}, 32'h0);
    wr(4'h3, 32'h1);
    cyc(1);
    check({31'h0, irq_out}, 32'h1);
    wr(4'h2, 32'h1);
    cyc(1);
    check({31'h0, irq_out}, 32'h0);
    @(posedge clk_in);
    hot_in <= 1'b1;
    cyc(10);
    check({30'h0, mode_out}, 32'h0);
    rd(4'h1);
    check({28'h0, d[3:0]}, 32'he);
    check({31'h0, irq_out}, 32'h0);
    wr(4'h3, 32'h2);
    cyc(1);
    check({31'h0, irq_out}, 32'h1);
    @(posedge clk_in);
    warn_in <= 1'b0;
    hot_in <= 1'b0;
    cyc(10);
    rd(4'h1);
    check({28'h0, d[3:0]}, 32'h0);
    wr(4'h2, 32'h7);
    cyc(1);
    check({31'h0, irq_out}, 32'h0);
    rd(4'h2);
    check({29'h0, d[2:0]}, 32'h0);
  end
  endtask
  task t_volt;
  begin
    for (i = 0; i < 2; i = i + 1)
    begin
      wr(4'h0, ctl(2'b11, 1'b0, i[0], 1'b0, 3'b000, 4'h0));
      cyc(3);
      check({31'h0, bias_out}, i);
    end
  end
  endtask
  task t_tmo;
  begin
    // Zero limits expire at once, so no long wait for a tick
    wr(4'h4, 32'h0000_0000);
    wr(4'h0, ctl(2'b10, 1'b0, 1'b0, 1'b0, 3'b001, 4'h0));
    cyc(3);
    check({29'h0, ftmo_out, mode_out}, 32'h4);
    wr(4'h0, ctl(2'b01, 1'b0, 1'b0, 1'b0, 3'b001, 4'h0));
    cyc(3);
    check({28'h0, ftmo_out, vtmo_out, mode_out}, 32'h4);
    rd(4'h2);
    check({31'h0, d[2]}, 32'h1);
  end
  endtask
  task report_and_stop;
  begin
    if (fail_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask
  initial
  begin
    repeat (90000) @(posedge clk_in);
    fail_count = fail_count + 1;
    report_and_stop;
  end
  initial
  begin
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    t_reset;
    t_ind;
    t_dim;
    t_temp;
    t_volt;
    t_tmo;
    report_and_stop;
  end
endmodule // testbench
